// file: pkg/psrm_regs.svh
/*
  Register map, field positions, reset values and pad masks of the pad signal routing matrix.
  Assumes word addressing on a plain register port with 32-bit data.
*/
// Contract
// - Pads 34 to 39 are input-only and are never driven.
// - Each of 162 peripheral inputs picks any pad as its source.
// - Each output pad takes one of 176 peripheral outputs by its select field.
// - Function select value 2 joins a pad to the crossbar; others are direct.
// - Pad input reaches crossbar and status only while input enable is set.
// - Input select 0x30 gives constant 0, 0x38 gives constant 1.
// - Input invert bit complements the selected input source.
// - One pad may feed any number of peripheral inputs at once.
// - Enable source bit set or output select 0x100 takes software enable; otherwise peripheral enable.
// - Software enables live in two registers, pads 0-31 and pads 32-39.
// - Open-drain bit makes the pad drive only low; clear means push-pull.
// - Each pad holds a two-bit drive strength, 0 to 3.
// - Each pad has independent pull-up and pull-down enables.
// - Output invert bit complements the value driven on the pad.
// - One peripheral output may drive several pads at once.
// - Output select 0x100 drives the pad from the software data bit.
// - Input status registers show pad levels without any crossbar routing.
// - Only 28 pads can drive; others ignore output settings.
// - Bypass bit routes the pad input straight to the peripheral.
// - Low-power pads hold output in deep sleep and may wake the chip.
// - Low-power route bits reset to 1; clearing hands the pad away.
`ifndef PSRM_REGS_SVH
`define PSRM_REGS_SVH
`define PSRM_NPAD      40
`define PSRM_NIN       162
`define PSRM_NOUT      176
`define PSRM_A_FMUX    10'h000
`define PSRM_A_OCFG    10'h040
`define PSRM_A_EN0     10'h080
`define PSRM_A_EN1     10'h081
`define PSRM_A_OUT0    10'h082
`define PSRM_A_OUT1    10'h083
`define PSRM_A_IN0     10'h084
`define PSRM_A_IN1     10'h085
`define PSRM_A_LPR0    10'h086
`define PSRM_A_LPR1    10'h087
`define PSRM_A_ICFG    10'h100
`define PSRM_FM_IE     3
`define PSRM_FM_PU     4
`define PSRM_FM_PD     5
`define PSRM_OC_INV    9
`define PSRM_OC_OENS   10
`define PSRM_OC_OD     11
`define PSRM_IC_INV    6
`define PSRM_IC_BYP    7
`define PSRM_FUNC_XBAR 3'h2
`define PSRM_IN_ZERO   6'h30
`define PSRM_IN_ONE    6'h38
`define PSRM_OUT_SW    9'h100
`define PSRM_FMUX_RST  8'h00
`define PSRM_OCFG_RST  12'h100
`define PSRM_ICFG_RST  8'h30
`define PSRM_LPR_RST   40'hFF_FFFF_FFFF
`define PSRM_PAD_EXIST 40'hFF_0EEF_FFFF
`define PSRM_PAD_OCAP  40'h03_0EEF_FFFF
`define PSRM_PAD_LPCAP 40'hFF_0E00_F015
`endif

// file: pkg/psrm_pkg.sv
/*
  Types shared by the pad signal routing matrix.
  Assumes the constants header is compiled alongside.
*/
package psrm_pkg;
  typedef logic [9:0]  psrm_addr_t;
  typedef logic [31:0] psrm_word_t;
  typedef logic [39:0] psrm_padv_t;
  typedef logic [7:0]  psrm_fmux_t;
  typedef logic [11:0] psrm_ocfg_t;
  typedef logic [7:0]  psrm_icfg_t;
endpackage

// file: hw/psrm_core.sv
/*
  Pad function multiplexer and full crossbar between peripheral signals and pads.
  Assumes peripheral signals and deep_sleep come from sys_clk logic; pad inputs are asynchronous.
*/
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "psrm_regs.svh"

module psrm_core
  import psrm_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire psrm_addr_t         bus_addr,
  input  wire psrm_word_t         bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_rd,
  output psrm_word_t              bus_rdata,
  input  wire psrm_padv_t         pad_in,
  output psrm_padv_t              pad_out,
  output psrm_padv_t              pad_oe,
  output psrm_padv_t              pad_pullup_enable,
  output psrm_padv_t              pad_pulldown_enable,
  output logic [79:0]             pad_drive_strength,
  input  wire logic [175:0]       periph_out,
  input  wire logic [175:0]       periph_oe,
  output logic [161:0]            periph_in,
  input  wire psrm_padv_t         direct_out,
  input  wire psrm_padv_t         direct_oe,
  input  wire psrm_padv_t         lp_out,
  input  wire psrm_padv_t         lp_oe,
  output psrm_padv_t              lp_pad_in,
  input  wire logic               deep_sleep,
  output logic                    lp_wake
);

  localparam psrm_padv_t EXIST = `PSRM_PAD_EXIST;
  localparam psrm_padv_t OCAP  = `PSRM_PAD_OCAP;
  localparam psrm_padv_t LPCAP = `PSRM_PAD_LPCAP;

  psrm_fmux_t   fmux_ff [`PSRM_NPAD];
  psrm_ocfg_t   ocfg_ff [`PSRM_NPAD];
  psrm_icfg_t   icfg_ff [`PSRM_NIN];
  psrm_padv_t   en_ff;
  psrm_padv_t   odata_ff;
  psrm_padv_t   lpr_ff;
  psrm_padv_t   sync1_ff;
  psrm_padv_t   sync2_ff;
  psrm_padv_t   pad_out_ff;
  psrm_padv_t   pad_oe_ff;
  psrm_padv_t   lp_in_ff;
  logic [161:0] periph_in_ff;
  psrm_word_t   rdata_ff;
  logic         wake_ff;
  psrm_word_t   nxt_rdata;
  wire  [39:0]  gated_in;
  wire  [39:0]  xbar_in;
  wire  [39:0]  nxt_pad_out;
  wire  [39:0]  nxt_pad_oe;
  wire  [161:0] nxt_periph_in;

  // Two-flop synchroniser on every pad; only the second stage feeds logic
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 40'h00_0000_0000;
      sync2_ff <= 40'h00_0000_0000;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Software enable, software data and low-power route registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_ff    <= 40'h00_0000_0000;
      odata_ff <= 40'h00_0000_0000;
      lpr_ff   <= `PSRM_LPR_RST;
    end else if (bus_wr) begin
      if (bus_addr == `PSRM_A_EN0) begin
        en_ff[31:0] <= bus_wdata;
      end
      if (bus_addr == `PSRM_A_EN1) begin
        en_ff[39:32] <= bus_wdata[7:0];
      end
      if (bus_addr == `PSRM_A_OUT0) begin
        odata_ff[31:0] <= bus_wdata;
      end
      if (bus_addr == `PSRM_A_OUT1) begin
        odata_ff[39:32] <= bus_wdata[7:0];
      end
      // Pads without a low-power side keep their route bit at 1
      if (bus_addr == `PSRM_A_LPR0) begin
        lpr_ff[31:0] <= bus_wdata | ~LPCAP[31:0];
      end
      if (bus_addr == `PSRM_A_LPR1) begin
        lpr_ff[39:32] <= bus_wdata[7:0] | ~LPCAP[39:32];
      end
    end
  end

  // Per-pad configuration, input gating and output path
  for (genvar gp = 0; gp < `PSRM_NPAD; gp++) begin : g_pad
    logic [8:0] osel;
    logic       pval;
    logic       poe;
    logic       xval;
    logic       xoe;
    logic       fval;
    logic       foe;
    logic       oval;
    logic       ooe;
    logic       held;

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        fmux_ff[gp] <= `PSRM_FMUX_RST;
        ocfg_ff[gp] <= `PSRM_OCFG_RST;
      end else if (bus_wr) begin
        if (bus_addr == `PSRM_A_FMUX + 10'(gp)) begin
          fmux_ff[gp] <= bus_wdata[7:0];
        end
        if (bus_addr == `PSRM_A_OCFG + 10'(gp)) begin
          ocfg_ff[gp] <= bus_wdata[11:0];
        end
      end
    end

    // Input enable gates the pad; a pad handed to low power is cut off
    assign gated_in[gp] = EXIST[gp] & fmux_ff[gp][`PSRM_FM_IE] & lpr_ff[gp] & sync2_ff[gp];
    assign xbar_in[gp]  = gated_in[gp] & (fmux_ff[gp][2:0] == `PSRM_FUNC_XBAR);

    // Crossbar output choice; out-of-range selects drive 0
    assign osel = ocfg_ff[gp][8:0];
    assign pval = (osel < 9'(`PSRM_NOUT)) ? periph_out[osel[7:0]] : 1'b0;
    assign poe  = (osel < 9'(`PSRM_NOUT)) ? periph_oe[osel[7:0]] : 1'b0;
    assign xval = ((osel == `PSRM_OUT_SW) ? odata_ff[gp] : pval) ^ ocfg_ff[gp][`PSRM_OC_INV];
    assign xoe  = (ocfg_ff[gp][`PSRM_OC_OENS] || osel == `PSRM_OUT_SW) ? en_ff[gp] : poe;

    // Function mux: value 2 takes the crossbar, anything else the direct function
    assign fval = (fmux_ff[gp][2:0] == `PSRM_FUNC_XBAR) ? xval : direct_out[gp];
    assign foe  = (fmux_ff[gp][2:0] == `PSRM_FUNC_XBAR) ? xoe : direct_oe[gp];

    // Open drain drives low only, releasing the pad for a high
    always_comb begin
      if (!lpr_ff[gp]) begin
        oval = lp_out[gp];
        ooe  = lp_oe[gp];
      end else if (ocfg_ff[gp][`PSRM_OC_OD]) begin
        oval = 1'b0;
        ooe  = foe & ~fval;
      end else begin
        oval = fval;
        ooe  = foe;
      end
    end

    // Low-power pads freeze their level while the chip sleeps
    assign held = deep_sleep & LPCAP[gp] & ~lpr_ff[gp];
    assign nxt_pad_out[gp] = held ? pad_out_ff[gp] : oval;
    // Input-only and absent pads never enable their driver
    assign nxt_pad_oe[gp]  = held ? pad_oe_ff[gp] : (ooe & OCAP[gp]);

    assign pad_pullup_enable[gp]        = fmux_ff[gp][`PSRM_FM_PU];
    assign pad_pulldown_enable[gp]      = fmux_ff[gp][`PSRM_FM_PD];
    assign pad_drive_strength[2*gp +: 2] = fmux_ff[gp][7:6];
  end

  // Per-signal input configuration and source selection
  for (genvar gi = 0; gi < `PSRM_NIN; gi++) begin : g_in
    logic [5:0] isel;
    logic       srcv;
    logic       bypv;

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        icfg_ff[gi] <= `PSRM_ICFG_RST;
      end else if (bus_wr && bus_addr == `PSRM_A_ICFG + 10'(gi)) begin
        icfg_ff[gi] <= bus_wdata[7:0];
      end
    end

    // Each signal reads any pad independently, so pads fan out freely
    assign isel = icfg_ff[gi][5:0];
    always_comb begin
      if (isel == `PSRM_IN_ZERO) begin
        srcv = 1'b0;
      end else if (isel == `PSRM_IN_ONE) begin
        srcv = 1'b1;
      end else if (isel < 6'(`PSRM_NPAD)) begin
        srcv = xbar_in[isel];
      end else begin
        srcv = 1'b0;
      end
    end
    // Bypass skips the crossbar, so no inversion and no function check
    assign bypv = (isel < 6'(`PSRM_NPAD)) ? gated_in[isel] : 1'b0;
    assign nxt_periph_in[gi] = icfg_ff[gi][`PSRM_IC_BYP] ? bypv : (srcv ^ icfg_ff[gi][`PSRM_IC_INV]);
  end

  // Registered pad and peripheral outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pad_out_ff   <= 40'h00_0000_0000;
      pad_oe_ff    <= 40'h00_0000_0000;
      periph_in_ff <= '0;
    end else begin
      pad_out_ff   <= nxt_pad_out;
      pad_oe_ff    <= nxt_pad_oe;
      periph_in_ff <= nxt_periph_in;
    end
  end

  // Low-power side: raw pad levels and wake request during sleep
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lp_in_ff <= 40'h00_0000_0000;
      wake_ff  <= 1'b0;
    end else begin
      lp_in_ff <= sync2_ff & LPCAP & ~lpr_ff;
      wake_ff  <= deep_sleep & |(sync2_ff & LPCAP & ~lpr_ff);
    end
  end

  // Read decode; unmapped words read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (bus_addr < `PSRM_A_FMUX + 10'(`PSRM_NPAD)) begin
      nxt_rdata = {24'h00_0000, fmux_ff[bus_addr[5:0]]};
    end else if (bus_addr >= `PSRM_A_OCFG && bus_addr < `PSRM_A_OCFG + 10'(`PSRM_NPAD)) begin
      nxt_rdata = {20'h0_0000, ocfg_ff[6'(bus_addr - `PSRM_A_OCFG)]};
    end else if (bus_addr >= `PSRM_A_ICFG && bus_addr < `PSRM_A_ICFG + 10'(`PSRM_NIN)) begin
      nxt_rdata = {24'h00_0000, icfg_ff[8'(bus_addr - `PSRM_A_ICFG)]};
    end else begin
      unique case (bus_addr)
        `PSRM_A_EN0:  nxt_rdata = en_ff[31:0];
        `PSRM_A_EN1:  nxt_rdata = {24'h00_0000, en_ff[39:32]};
        `PSRM_A_OUT0: nxt_rdata = odata_ff[31:0];
        `PSRM_A_OUT1: nxt_rdata = {24'h00_0000, odata_ff[39:32]};
        `PSRM_A_IN0:  nxt_rdata = gated_in[31:0];
        `PSRM_A_IN1:  nxt_rdata = {24'h00_0000, gated_in[39:32]};
        `PSRM_A_LPR0: nxt_rdata = lpr_ff[31:0];
        `PSRM_A_LPR1: nxt_rdata = {24'h00_0000, lpr_ff[39:32]};
        default:      nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= bus_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign bus_rdata = rdata_ff;
  assign pad_out   = pad_out_ff;
  assign pad_oe    = pad_oe_ff;
  assign periph_in = periph_in_ff;
  assign lp_pad_in = lp_in_ff;
  assign lp_wake   = wake_ff;

  // Checks on the routed behaviour
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_input_only_off: assert property (
    pad_oe_ff[39:34] == 6'h00
  ) else $error("input-only pad driven");

  a_noncap_pads_off: assert property (
    (pad_oe_ff & ~OCAP) == 40'h00_0000_0000
  ) else $error("pad outside output set driven");

  a_const_zero_src: assert property (
    (icfg_ff[0] == 8'h30) |=> !periph_in_ff[0]
  ) else $error("constant zero source not zero");

  a_const_one_src: assert property (
    (icfg_ff[0] == 8'h38) |=> periph_in_ff[0]
  ) else $error("constant one source not one");

  a_input_inverted: assert property (
    (icfg_ff[1] == 8'h78) |=> !periph_in_ff[1]
  ) else $error("inverted constant one not zero");

  a_disabled_pad_zero: assert property (
    (icfg_ff[2][5:0] == 6'h05 && icfg_ff[2][7:6] == 2'b00 && !fmux_ff[5][3]) |=> !periph_in_ff[2]
  ) else $error("disabled pad leaked into input");

  a_status_gated: assert property (
    (bus_rd && bus_addr == `PSRM_A_IN0 && !fmux_ff[1][3]) |=> !bus_rdata[1]
  ) else $error("status shows pad with input off");

  a_sw_data_drive: assert property (
    (ocfg_ff[3] == 12'h100 && fmux_ff[3][2:0] == 3'h2) |=> (pad_out_ff[3] == $past(odata_ff[3]))
  ) else $error("software data not on pad");

  a_sw_enable_src: assert property (
    (ocfg_ff[3][11:10] == 2'b01 && fmux_ff[3][2:0] == 3'h2) |=> (pad_oe_ff[3] == $past(en_ff[3]))
  ) else $error("software enable not used");

  a_open_drain_low: assert property (
    (ocfg_ff[3][11] && lpr_ff[3]) |=> !pad_out_ff[3]
  ) else $error("open drain pad drove high");

  a_sleep_hold: assert property (
    (deep_sleep && !lpr_ff[0]) |=> $stable(pad_out_ff[0]) && $stable(pad_oe_ff[0])
  ) else $error("sleeping pad changed level");

  c_sw_output: cover property (
    ocfg_ff[3] == 12'h100 && en_ff[3] ##1 pad_oe_ff[3]
  );

  c_const_one: cover property (
    icfg_ff[0] == 8'h38 ##1 periph_in_ff[0]
  );

  c_open_drain_low: cover property (
    ocfg_ff[3][11] ##1 pad_oe_ff[3] && !pad_out_ff[3]
  );

  c_sleep_wake: cover property (
    deep_sleep ##1 lp_wake
  );

endmodule

// file: sim/psrm_pad_model.sv
/*
  Behavioural model of the pads outside the routing matrix: external drivers, pulls and floating lines.
  Assumes the bench chooses which pads it drives from outside and never drives a pad the matrix enables.
*/
`timescale 1ns/1ps

module psrm_pad_model
  import psrm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire psrm_padv_t pad_out,
  input  wire psrm_padv_t pad_oe,
  input  wire psrm_padv_t pad_pullup_enable,
  input  wire psrm_padv_t pad_pulldown_enable,
  input  wire psrm_padv_t ext_en,
  input  wire psrm_padv_t ext_val,
  output psrm_padv_t      pad_level
);
  psrm_padv_t last_ff = 40'h0;

  // Remember the level so a floating pad can flip away from it
  always @(posedge sys_clk) begin
    last_ff <= pad_level;
  end

  // Matrix driver wins, then external driver, then pulls; a floating pad toggles every cycle
  always_comb begin
    for (int n = 0; n < 40; n++) begin
      if (pad_oe[n]) pad_level[n] = pad_out[n];
      else if (ext_en[n]) pad_level[n] = ext_val[n];
      else if (pad_pullup_enable[n]) pad_level[n] = 1'b1;
      else if (pad_pulldown_enable[n]) pad_level[n] = 1'b0;
      else pad_level[n] = ~last_ff[n];
    end
  end
endmodule

// file: sim/tb_pad_signal_routing_matrix.sv
/*
  Self-checking bench of the routing matrix: register port, output crossbar, input crossbar and pad controls.
  Assumes the pad model closes the pad loop and the register map of the constants header.
*/
`timescale 1ns/1ps
`include "psrm_regs.svh"

module tb_pad_signal_routing_matrix
  import psrm_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  psrm_addr_t  bus_addr = 10'h0;
  psrm_word_t  bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  psrm_word_t  bus_rdata;
  psrm_padv_t  pad_out, pad_oe, pull_up, pull_dn, pad_level;
  psrm_padv_t  ext_en = 40'h04_0000_0004;
  psrm_padv_t  ext_val = 40'h0;
  logic [79:0]  drv;
  logic [175:0] periph_out = 176'h0;
  logic [175:0] periph_oe = 176'h0;
  logic [161:0] periph_in;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          mdl [int];
  psrm_word_t  rdv;
  int          k, r;
  int          regs_a [7] = '{`PSRM_A_FMUX, `PSRM_A_OCFG, `PSRM_A_ICFG, `PSRM_A_EN0, `PSRM_A_LPR0, `PSRM_A_LPR1, 'h3FF};
  int          opads [2] = '{3, 5};
  int          icv [6];
  logic [1:0]  ed;
  logic        deep_sleep = 1'b0;

  psrm_core uut (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_enable(pull_up), .pad_pulldown_enable(pull_dn), .pad_drive_strength(drv),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .direct_out(40'h0),
    .direct_oe(40'h0), .lp_out(40'h0), .lp_oe(40'h0), .lp_pad_in(), .deep_sleep(deep_sleep), .lp_wake());

  psrm_pad_model pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_enable(pull_up),
    .pad_pulldown_enable(pull_dn), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_level));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  // Model register value, falling back to the reset value of never-written places
  function automatic int rv(int a);
    if (mdl.exists(a)) return mdl[a];
    if (a >= `PSRM_A_ICFG && a < `PSRM_A_ICFG + `PSRM_NIN) return 'h30;
    if (a >= `PSRM_A_OCFG && a < `PSRM_A_OCFG + `PSRM_NPAD) return 'h100;
    if (a == `PSRM_A_LPR0) return 'hFFFFFFFF;
    if (a == `PSRM_A_LPR1) return 'hFF;
    return 0;
  endfunction

  function automatic logic pbit(int base, int n);
    return 1'(rv(base + n / 32) >> (n % 32));
  endfunction

  // Expected {enable, value} of an output pad
  function automatic logic [1:0] exp_drv(int n);
    int oc, sel;
    logic v, e;
    oc = rv(`PSRM_A_OCFG + n);
    sel = oc & 'h1FF;
    v = (sel == 'h100) ? pbit(`PSRM_A_OUT0, n) : (sel < 176) ? periph_out[sel] : 1'b0;
    v = v ^ oc[9];
    e = (oc[10] || sel == 'h100) ? pbit(`PSRM_A_EN0, n) : (sel < 176) ? periph_oe[sel] : 1'b0;
    if (!((`PSRM_PAD_OCAP >> n) & 1) || (rv(n) & 7) != 2 || !pbit(`PSRM_A_LPR0, n)) e = 1'b0;
    if (oc[11]) e = e & ~v;
    return {e, oc[11] ? 1'b0 : v};
  endfunction

  // Expected routed input of peripheral signal k
  function automatic logic exp_in(int k);
    int ic, src;
    logic live;
    ic = rv(`PSRM_A_ICFG + k);
    src = ic & 'h3F;
    live = (src < 40) ? pad_level[src] & rv(src) >> 3 : 1'b0;
    if (ic[7]) return live;
    live = (src == 'h30) ? 1'b0 : (src == 'h38) ? 1'b1 : ((rv(src) & 7) == 2) ? live : 1'b0;
    return live ^ ic[6];
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(int a, int d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= 10'(a);
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    mdl[a] = d;
  endtask

  task automatic rd(int a, output psrm_word_t d);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= 10'(a);
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rdchk(int a);
    psrm_word_t d;
    rd(a, d);
    chk("register read", rv(a), d);
  endtask

  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h8fdec747));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, then unmapped place written and read as zero
    foreach (regs_a[i])
      rdchk(regs_a[i]);
    wr('h3FF, 'h5A);
    mdl.delete('h3FF);
    rdchk('h3FF);
    // Output crossbar on pads 3 and 5 sharing one source, then input-only pad 35
    for (int it = 0; it < 8; it++) begin
      k = (it == 0) ? 'h100 : $urandom_range(0, 175);
      r = k | ($urandom_range(0, 3) << 9) | ((it == 7) << 11);
      periph_out <= 176'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      periph_oe <= 176'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      wr(`PSRM_A_OCFG + 3, r);
      wr(`PSRM_A_OCFG + 5, r);
      wr(3, 2);
      wr(5, 2);
      wr(`PSRM_A_EN0, $urandom & 'h28);
      wr(`PSRM_A_OUT0, $urandom);
      settle();
      foreach (opads[i]) begin
        ed = exp_drv(opads[i]);
        chk("pad enable", ed[1], pad_oe[opads[i]]);
        if (ed[1])
          chk("pad value", ed[0], pad_out[opads[i]]);
      end
    end
    rdchk(`PSRM_A_OCFG + 3);
    wr(`PSRM_A_OCFG + 35, 'h100);
    wr(35, 2);
    wr(`PSRM_A_EN1, 'hFF);
    wr(`PSRM_A_OUT1, 'hFF);
    settle();
    chk("input-only pad enable", 0, pad_oe[39:34]);
    // Input crossbar: pad 2 and pad 34 fan out, constants, inversion, bypass
    for (int it = 0; it < 4; it++) begin
      ext_val <= 40'({$urandom, $urandom});
      wr(2, (it == 3) ? 'h02 : 'h0A);
      wr(34, (it % 2) ? 'h08 : 'h0A);
      icv = '{'h02, 'h42, 'h30 | (it << 6), 'h78, 'hA2, 'h22};
      foreach (icv[i])
        wr(`PSRM_A_ICFG + i, icv[i]);
      settle();
      for (int s = 0; s < 6; s++) chk("peripheral input", exp_in(s), periph_in[s]);
      rd(`PSRM_A_IN0, rdv);
      chk("status low", {29'h0, pad_level[2] & (it != 3), 2'h0}, rdv);
      rd(`PSRM_A_IN1, rdv);
      chk("status high", {29'h0, pad_level[34], 2'h0}, rdv);
    end
    wr(`PSRM_A_IN0, 'hFFFF_FFFF);
    rd(`PSRM_A_IN0, rdv);
    chk("read-only status", 0, rdv);
    // Pulls and drive strength on pad 1
    for (int it = 0; it < 4; it++) begin
      r = ($urandom & 'hF0) | (it << 6);
      wr(1, r);
      settle();
      chk("pad controls", {r[7:6], r[5], r[4]}, {drv[3:2], pull_dn[1], pull_up[1]});
      rdchk(1);
    end
    // Pad 0 handed to low power, then held through deep sleep
    wr(`PSRM_A_LPR0, 'hFFFF_FFFE);
    rdchk(`PSRM_A_LPR0);
    deep_sleep <= 1'b1;
    settle();
    chk("sleeping pad enable", 0, pad_oe[0]);
    deep_sleep <= 1'b0;
    print_verdict();
  end
endmodule
